/* design/usrx_pkg.sv */
// constants shared by the serial receive path: register indexes, field
// positions, reset values, oversampling figures and the receiver states.
// assumes a 40 MHz REF_CLK and a 32-bit AXI4-Lite register port.
//
// Notes on behaviour
// [RL1] line is sampled on a x16 baud tick; shifter moves once per bit
// [RL2] async reception starts only while continuous receive enable is set
// [RL3] after stop bit, word goes into fifo if room; receive flag then set
// [RL4] receive flag is read-only; clears once data read and fifo empty
// [RL5] receive flag raises a request only while its enable bit is set
// [RL6] receive data is a two-entry fifo; two reads return both in order
// [RL7] fifo full at a further stop bit: set overrun, drop that word
// [RL8] overrun clears only by dropping then raising continuous receive enable
// [RL9] while overrun stands, no word moves from shifter into the fifo
// [RL10] a stop bit sampled low sets the framing error bit
// [RL11] framing error and ninth bit queue with data; read status first
// [RL12] sync slave receive acts as master receive; single receive ignored
// [RL13] sync slave with continuous receive keeps receiving during sleep
// [RL14] word finished in sleep wakes core if enabled; vector 0004h
// [RL15] software sets sync, port enable, clears master, then receive enable
// [RL16] software reads status, then data, clears errors via receive enable
// [RL17] core request also needs global enable and peripheral gate set
// [RL18] software keeps parallel port flag and enable bits at zero
// [RL19] async start is a falling edge on idle-high line; data lsb first

package usrx_pkg;

  // ===========================================================
  // register indexes (byte address is four times the index)
  localparam int USRX_AW = 12;
  localparam int USRX_IW = 10;
  localparam logic [9:0] IDX_INTERRUPT_CONTROL = 10'h00B;
  localparam logic [9:0] IDX_PERIPHERAL_IRQ_FLAGS = 10'h00C;
  localparam logic [9:0] IDX_RECEIVE_STATUS_CONTROL = 10'h018;
  localparam logic [9:0] IDX_RECEIVE_DATA_FIFO = 10'h01A;
  localparam logic [9:0] IDX_PERIPHERAL_IRQ_ENABLES = 10'h08C;
  localparam logic [9:0] IDX_TRANSMIT_STATUS_CONTROL = 10'h098;
  localparam logic [9:0] IDX_BAUD_DIVISOR = 10'h099;
  localparam logic [9:0] IDX_EVENT_STATUS = 10'h0A0;
  localparam logic [9:0] IDX_EVENT_MASK = 10'h0A1;

  // ===========================================================
  // field positions
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PERIPHERAL_IRQ_GATE_BIT = 6;
  localparam int RECEIVE_FLAG_BIT = 5;
  localparam int RECEIVE_IRQ_ENABLE_BIT = 5;
  localparam int SERIAL_PORT_ENABLE_BIT = 7;
  localparam int NINE_BIT_SELECT_BIT = 6;
  localparam int CONT_RECEIVE_ENABLE_BIT = 4;
  localparam int FRAMING_ERROR_BIT = 2;
  localparam int OVERRUN_ERROR_BIT = 1;
  localparam int NINTH_RX_BIT_BIT = 0;
  localparam int CLOCK_SOURCE_MASTER_BIT = 7;
  localparam int SYNC_MODE_SELECT_BIT = 4;
  localparam int EVT_RECEIVED_BIT = 0;
  localparam int EVT_FRAMING_BIT = 1;
  localparam int EVT_OVERRUN_BIT = 2;

  // ===========================================================
  // reset values and fixed bits
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RST_RECEIVE_CONTROL = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLES = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_CONTROL = 8'h02;
  localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;
  localparam logic [7:0] RST_EVENT_MASK = 8'h00;
  localparam logic [7:0] TXSC_RO_MASK = 8'h0A;
  localparam logic [7:0] TXSC_FIXED = 8'h02;

  // ===========================================================
  // timing and protocol figures
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] START_MID_TICK = 4'h7;
  localparam logic [15:0] IRQ_VECTOR_ADDR = 16'h0004;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b10,
    ST_STOP = 2'b11
  } usrx_state_e;

  // word index of a byte address
  function automatic logic [9:0] usrx_word(input logic [USRX_AW-1:0] a);
    return a[USRX_AW-1:2];
  endfunction

  // true for an index that holds a register
  function automatic logic usrx_mapped(input logic [9:0] i);
    return (i == IDX_INTERRUPT_CONTROL) || (i == IDX_PERIPHERAL_IRQ_FLAGS) ||
      (i == IDX_RECEIVE_STATUS_CONTROL) || (i == IDX_RECEIVE_DATA_FIFO) ||
      (i == IDX_PERIPHERAL_IRQ_ENABLES) || (i == IDX_TRANSMIT_STATUS_CONTROL) ||
      (i == IDX_BAUD_DIVISOR) || (i == IDX_EVENT_STATUS) || (i == IDX_EVENT_MASK);
  endfunction

endpackage

/* design/usrx_receive_path.sv */
// serial receive path: async x16 receiver, sync slave receiver,
// receive fifo with queued framing error and ninth bit, AXI4-Lite registers, interrupts.
// assumes line and clock pins already synchronous to REF_CLK.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module usrx_receive_path import usrx_pkg::*; #(
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // AXI4-Lite write channels
  input wire logic [USRX_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read channels
  input wire logic [USRX_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // serial line
  input wire logic RECEIVE_LINE_PIN,
  input wire logic SYNC_CLOCK_PIN,
  // core side
  input wire logic SLEEP_ACTIVE,
  output logic IRQ,
  output logic RECEIVE_IRQ,
  output logic WAKE_REQ,
  output logic [15:0] IRQ_VECTOR
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  // ===========================================================
  // bus slave state
  logic awready_reg, wready_reg, bvalid_reg;
  logic [1:0] bresp_reg;
  logic [USRX_AW-1:0] aw_addr_reg;
  logic [7:0] w_byte_reg;
  logic w_lane_reg;
  logic arready_reg, rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic wr_go, rd_go, wr_en;
  logic [9:0] wr_idx, rd_idx;
  logic [7:0] rd_byte;

  // ===========================================================
  // software registers and receiver state
  logic [7:0] intctl_reg, enables_reg, txsc_reg, baud_reg, mask_reg;
  logic [7:3] rxctl_reg;
  logic [2:0] status_reg;
  logic overrun_error_reg, receive_flag_reg;
  logic irq_reg, rcv_irq_reg, wake_reg;
  logic [15:0] vector_reg;
  usrx_state_e state_reg;
  logic [7:0] brg_cnt_reg;
  logic [3:0] os_cnt_reg, bit_cnt_reg;
  logic [8:0] shift_reg;
  logic line_prev_reg, ck_prev_reg;
  logic done_reg, done_framing_error_reg, done_ninth_reg;
  logic [7:0] done_data_reg;
  logic [7:0] fifo_data [DEPTH];
  logic fifo_ninth [DEPTH];
  logic fifo_framing_error [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [CNT_W-1:0] count_reg, count_next;

  // ===========================================================
  // control decode
  logic port_en, continuous_receive_enable, nine, sync_mode, master, sync_slave;
  logic rx_active, tick, ck_rise, line_fall, last_bit;
  logic push, pop, ovf_evt, stat_clear;
  logic [2:0] evt;

  assign port_en = rxctl_reg[SERIAL_PORT_ENABLE_BIT];
  assign continuous_receive_enable = rxctl_reg[CONT_RECEIVE_ENABLE_BIT];
  assign nine = rxctl_reg[NINE_BIT_SELECT_BIT];
  assign sync_mode = txsc_reg[SYNC_MODE_SELECT_BIT];
  assign master = txsc_reg[CLOCK_SOURCE_MASTER_BIT];
  // single receive enable is never looked at: slave needs no strobe [RL12]
  assign sync_slave = sync_mode && !master;
  // async stops in sleep (core clock gone); sync slave runs on [RL2] [RL13]
  assign rx_active = port_en && continuous_receive_enable && (!SLEEP_ACTIVE || sync_slave);
  assign tick = (brg_cnt_reg == baud_reg);
  assign ck_rise = SYNC_CLOCK_PIN && !ck_prev_reg;
  assign line_fall = line_prev_reg && !RECEIVE_LINE_PIN;
  assign last_bit = (bit_cnt_reg == (nine ? 4'h8 : 4'h7));

  // baud divider: one tick per (divisor+1) clocks, sixteen per bit [RL1]
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      brg_cnt_reg <= 8'h00;
    end else if (tick || !rx_active) begin
      brg_cnt_reg <= 8'h00;
    end else begin
      brg_cnt_reg <= brg_cnt_reg + 8'h01;
    end
  end

  // previous pin levels for edge detection
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      line_prev_reg <= 1'b1;
      ck_prev_reg <= 1'b0;
    end else begin
      line_prev_reg <= RECEIVE_LINE_PIN;
      ck_prev_reg <= SYNC_CLOCK_PIN;
    end
  end

  // ===========================================================
  // receive shifter; a frame in flight is dropped when reception stops
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
      os_cnt_reg <= 4'h0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 9'h000;
      done_reg <= 1'b0;
      done_framing_error_reg <= 1'b0;
      done_ninth_reg <= 1'b0;
      done_data_reg <= 8'h00;
    end else begin
      done_reg <= 1'b0;
      if (!rx_active) begin
        state_reg <= ST_IDLE;
        os_cnt_reg <= 4'h0;
        bit_cnt_reg <= 4'h0;
      end else if (sync_slave) begin
        // data taken on the rising edge of the master's clock
        state_reg <= ST_IDLE;
        if (ck_rise) begin
          shift_reg <= {RECEIVE_LINE_PIN, shift_reg[8:1]}; // [RL19]
          if (last_bit) begin
            bit_cnt_reg <= 4'h0;
            done_reg <= 1'b1; // [RL13]
            done_framing_error_reg <= 1'b0;
            done_ninth_reg <= nine ? RECEIVE_LINE_PIN : 1'b0;
            done_data_reg <= nine ? shift_reg[8:1] : {RECEIVE_LINE_PIN, shift_reg[8:2]};
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
      end else begin
        case (state_reg)
          ST_IDLE: begin
            os_cnt_reg <= 4'h0;
            bit_cnt_reg <= 4'h0;
            if (line_fall) begin
              state_reg <= ST_START; // [RL19]
            end
          end
          ST_START: begin
            if (tick) begin
              os_cnt_reg <= os_cnt_reg + 4'h1;
              if (os_cnt_reg == START_MID_TICK) begin
                // a glitch shorter than half a bit is not a start
                state_reg <= RECEIVE_LINE_PIN ? ST_IDLE : ST_DATA;
                os_cnt_reg <= 4'h0;
              end
            end
          end
          ST_DATA: begin
            if (tick) begin
              os_cnt_reg <= os_cnt_reg + 4'h1;
              if (os_cnt_reg == OVERSAMPLE_LAST) begin
                // one shift per bit, lsb first [RL1] [RL19]
                shift_reg <= {RECEIVE_LINE_PIN, shift_reg[8:1]};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (last_bit) begin
                  state_reg <= ST_STOP;
                end
              end
            end
          end
          ST_STOP: begin
            if (tick) begin
              os_cnt_reg <= os_cnt_reg + 4'h1;
              if (os_cnt_reg == OVERSAMPLE_LAST) begin
                state_reg <= ST_IDLE;
                done_reg <= 1'b1;
                done_framing_error_reg <= !RECEIVE_LINE_PIN; // [RL10]
                done_ninth_reg <= nine ? shift_reg[8] : 1'b0;
                done_data_reg <= nine ? shift_reg[7:0] : shift_reg[8:1];
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ===========================================================
  // fifo control; push only with room and no overrun standing
  assign push = done_reg && !overrun_error_reg && (count_reg < FULL_CNT); // [RL3] [RL9]
  assign ovf_evt = done_reg && !overrun_error_reg && (count_reg == FULL_CNT); // [RL7]
  assign pop = rd_go && (rd_idx == IDX_RECEIVE_DATA_FIFO) && (count_reg != '0);

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // storage: data, framing error and ninth bit travel together [RL6] [RL11]
  always_ff @(posedge REF_CLK) begin
    if (push) begin
      fifo_data[wr_ptr_reg] <= done_data_reg;
      fifo_ninth[wr_ptr_reg] <= done_ninth_reg;
      fifo_framing_error[wr_ptr_reg] <= done_framing_error_reg;
    end
  end

  // pointers, count and the receive flag, which tracks fill level [RL3] [RL4]
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      receive_flag_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      receive_flag_reg <= (count_next != '0);
    end
  end

  // overrun: a set in the same cycle as the clear wins [RL7] [RL8]
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      overrun_error_reg <= 1'b0;
    end else if (ovf_evt) begin
      overrun_error_reg <= 1'b1;
    end else if (!continuous_receive_enable) begin
      overrun_error_reg <= 1'b0;
    end
  end

  // ===========================================================
  // AXI4-Lite write side: address and data taken in either order
  assign wr_go = !awready_reg && !wready_reg && !bvalid_reg;
  assign wr_idx = usrx_word(aw_addr_reg);
  assign wr_en = wr_go && w_lane_reg;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      aw_addr_reg <= '0;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && awready_reg) begin
        awready_reg <= 1'b0;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && wready_reg) begin
        wready_reg <= 1'b0;
        w_byte_reg <= S_AXI_WDATA[7:0];
        w_lane_reg <= S_AXI_WSTRB[0];
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= usrx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // writable registers; read-only bits and lanes above byte 0 are dropped
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      intctl_reg <= RST_INTERRUPT_CONTROL;
      rxctl_reg <= RST_RECEIVE_CONTROL[7:3];
      enables_reg <= RST_IRQ_ENABLES;
      txsc_reg <= RST_TRANSMIT_CONTROL;
      baud_reg <= RST_BAUD_DIVISOR;
      mask_reg <= RST_EVENT_MASK;
    end else if (wr_en) begin
      case (wr_idx)
        IDX_INTERRUPT_CONTROL: intctl_reg <= w_byte_reg;
        IDX_RECEIVE_STATUS_CONTROL: rxctl_reg <= w_byte_reg[7:3];
        IDX_PERIPHERAL_IRQ_ENABLES: enables_reg <= w_byte_reg;
        IDX_TRANSMIT_STATUS_CONTROL: txsc_reg <= (w_byte_reg & ~TXSC_RO_MASK) | TXSC_FIXED;
        IDX_BAUD_DIVISOR: baud_reg <= w_byte_reg;
        IDX_EVENT_MASK: mask_reg <= w_byte_reg;
        default: begin
        end
      endcase
    end
  end

  // ===========================================================
  // AXI4-Lite read side; framing error and ninth bit shown are those of the fifo head
  assign rd_go = S_AXI_ARVALID && arready_reg;
  assign rd_idx = usrx_word(S_AXI_ARADDR);

  always_comb begin
    rd_byte = 8'h00;
    case (rd_idx)
      IDX_INTERRUPT_CONTROL: rd_byte = intctl_reg;
      IDX_PERIPHERAL_IRQ_FLAGS: rd_byte[RECEIVE_FLAG_BIT] = receive_flag_reg;
      IDX_RECEIVE_STATUS_CONTROL: begin
        rd_byte[7:3] = rxctl_reg;
        rd_byte[FRAMING_ERROR_BIT] = (count_reg != '0) && fifo_framing_error[rd_ptr_reg];
        rd_byte[OVERRUN_ERROR_BIT] = overrun_error_reg;
        rd_byte[NINTH_RX_BIT_BIT] = (count_reg != '0) && fifo_ninth[rd_ptr_reg];
      end
      IDX_RECEIVE_DATA_FIFO: rd_byte = (count_reg != '0) ? fifo_data[rd_ptr_reg] : 8'h00;
      IDX_PERIPHERAL_IRQ_ENABLES: rd_byte = enables_reg;
      IDX_TRANSMIT_STATUS_CONTROL: rd_byte = txsc_reg;
      IDX_BAUD_DIVISOR: rd_byte = baud_reg;
      IDX_EVENT_STATUS: rd_byte = {5'b00000, status_reg};
      IDX_EVENT_MASK: rd_byte = mask_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else begin
      if (rd_go) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= {24'h000000, rd_byte};
        rresp_reg <= usrx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_reg && S_AXI_RREADY) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // ===========================================================
  // sticky event status, cleared by reading it; new events win
  assign stat_clear = rd_go && (rd_idx == IDX_EVENT_STATUS);
  assign evt = {ovf_evt, push && done_framing_error_reg, push};

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      status_reg <= 3'b000;
    end else begin
      status_reg <= (stat_clear ? 3'b000 : status_reg) | evt;
    end
  end

  // interrupt outputs, all registered
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_reg <= 1'b0;
      rcv_irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      vector_reg <= 16'h0000;
    end else begin
      irq_reg <= |(status_reg & mask_reg[2:0]);
      rcv_irq_reg <= receive_flag_reg && enables_reg[RECEIVE_IRQ_ENABLE_BIT] &&
        intctl_reg[GLOBAL_IRQ_ENABLE_BIT] && intctl_reg[PERIPHERAL_IRQ_GATE_BIT]; // [RL5] [RL17]
      wake_reg <= receive_flag_reg && enables_reg[RECEIVE_IRQ_ENABLE_BIT] &&
        SLEEP_ACTIVE; // [RL14]
      vector_reg <= (receive_flag_reg && enables_reg[RECEIVE_IRQ_ENABLE_BIT] &&
        intctl_reg[GLOBAL_IRQ_ENABLE_BIT] && intctl_reg[PERIPHERAL_IRQ_GATE_BIT]) ?
        IRQ_VECTOR_ADDR : 16'h0000; // [RL14]
    end
  end

  assign S_AXI_AWREADY = awready_reg;
  assign S_AXI_WREADY = wready_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign IRQ = irq_reg;
  assign RECEIVE_IRQ = rcv_irq_reg;
  assign WAKE_REQ = wake_reg;
  assign IRQ_VECTOR = vector_reg;

  // ===========================================================
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  chk_bit_timing: assert property ( // [RL1]
    (state_reg == ST_DATA) && $changed(bit_cnt_reg) && rx_active |->
      $past(tick) && ($past(os_cnt_reg) == OVERSAMPLE_LAST))
    else $error("async bit shifted off the sixteenth tick");
  chk_enable_gate: assert property ( // [RL2]
    !continuous_receive_enable |=> (state_reg == ST_IDLE) && !done_reg)
    else $error("receiver ran without continuous receive enable");
  chk_push_flag: assert property ( // [RL3]
    push |=> receive_flag_reg && (count_reg != '0))
    else $error("receive flag not set after fifo push");
  chk_flag_level: assert property ( // [RL4]
    receive_flag_reg == (count_reg != '0))
    else $error("receive flag disagrees with fifo fill");
  chk_irq_gate: assert property ( // [RL5]
    RECEIVE_IRQ |-> $past(enables_reg[RECEIVE_IRQ_ENABLE_BIT] && receive_flag_reg &&
      intctl_reg[GLOBAL_IRQ_ENABLE_BIT] && intctl_reg[PERIPHERAL_IRQ_GATE_BIT]))
    else $error("receive request without its enables");
  chk_fifo_depth: assert property ( // [RL6]
    (count_reg == FULL_CNT) && !pop |=> count_reg == FULL_CNT)
    else $error("full fifo lost an entry without a read");
  chk_overrun_set: assert property ( // [RL7]
    done_reg && !overrun_error_reg && (count_reg == FULL_CNT) |=> overrun_error_reg ##1 overrun_error_reg || !continuous_receive_enable)
    else $error("overrun not raised on full fifo");
  chk_overrun_clear: assert property ( // [RL8]
    !continuous_receive_enable && !done_reg |=> !overrun_error_reg)
    else $error("overrun survived receive enable clear");
  chk_overrun_block: assert property ( // [RL9]
    overrun_error_reg |-> !push)
    else $error("fifo written while overrun stands");
  chk_framing: assert property ( // [RL10]
    rx_active && !sync_slave && (state_reg == ST_STOP) && tick &&
      (os_cnt_reg == OVERSAMPLE_LAST) && !RECEIVE_LINE_PIN |=> done_reg && done_framing_error_reg)
    else $error("low stop bit not flagged");
  chk_sleep_slave: assert property ( // [RL13]
    sync_slave && port_en && continuous_receive_enable |-> rx_active)
    else $error("sync slave receive stopped");
  chk_wake: assert property ( // [RL14]
    receive_flag_reg && enables_reg[RECEIVE_IRQ_ENABLE_BIT] && SLEEP_ACTIVE |=> WAKE_REQ)
    else $error("no wake for character in sleep");

  cov_push: cover property (push ##1 push);
  cov_overrun: cover property (ovf_evt);
  cov_framing: cover property (push && done_framing_error_reg);
  cov_wake: cover property (sync_slave && SLEEP_ACTIVE && push);

endmodule

/* bench/usrx_line_model.sv */
// far-end serial transmitter or sync master: sends one frame or word per call.
// assumes the receiver ticks x16 once per REF_CLK, so a bit is 16 clocks.
`timescale 1ns/1ps

module usrx_line_model #(
  parameter int BIT_CLKS = 16
) (
  // clock and line
  input wire logic ref_clk,
  output logic line_o,
  output logic ck_o
);
  // ===========================================================
  // frame generator
  initial line_o = 1'b1; // idle high between frames
  initial ck_o = 1'b0; // sync clock rests low outside words
  // start low, data lsb first, then a chosen stop level
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      line_o <= f[i];
      repeat (BIT_CLKS - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    line_o <= 1'b1;
    // a bad stop shows if the line is still low when the receiver samples the stop bit, mid-bit
    repeat (BIT_CLKS) @(posedge ref_clk);
  endtask
  // sync master word, lsb first; line set up two clocks before each rise
  task automatic send_sync(input logic [8:0] d, input int nb);
    for (int i = 0; i < nb; i++) begin
      @(posedge ref_clk);
      line_o <= d[i];
      ck_o <= 1'b0;
      repeat (2) @(posedge ref_clk);
      ck_o <= 1'b1;
      repeat (2) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    ck_o <= 1'b0;
    line_o <= 1'b1;
  endtask
endmodule

/* bench/tb_usart_receive_path.sv */
// testbench: registers over AXI4-Lite, line frames through the model.
// assumes the package and receive path are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end

module tb_usart_receive_path import usrx_pkg::*; ;
  logic REF_CLK, RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, RECEIVE_LINE_PIN, SYNC_CLOCK_PIN, SLEEP_ACTIVE, IRQ, RECEIVE_IRQ, WAKE_REQ;
  logic [USRX_AW-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rd_resp;
  logic [15:0] IRQ_VECTOR;
  logic [7:0] rd_data;
  int n_errors = 0;
  int cmp_count = 0;

  usrx_receive_path i_dut (.*);
  usrx_line_model i_line (.ref_clk(REF_CLK), .line_o(RECEIVE_LINE_PIN), .ck_o(SYNC_CLOCK_PIN));

  // ===========================================================
  // clock, 25 ns period
  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end

  // ===========================================================
  // bus tasks; each opens on a fresh edge so no signal is set twice at once
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge REF_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    do begin
      @(posedge REF_CLK);
      n++;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1 && n < 20);
    S_AXI_BREADY <= 1'b0;
    if (S_AXI_BVALID !== 1'b1) begin n_errors++; tally_and_finish; end
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [7:0] e);
    int n;
    n = 0;
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do begin
      @(posedge REF_CLK);
      n++;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1 && n < 20);
    rd_data = S_AXI_RDATA[7:0];
    rd_resp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    if (S_AXI_RVALID !== 1'b1) begin n_errors++; tally_and_finish; end
    `CHK($sformatf("reg %h", a), e, rd_data)
  endtask

  // ===========================================================
  // main sequence; async path first, then a sync slave word with sleep active
  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, SLEEP_ACTIVE, RST_N} = '0;
    S_AXI_WSTRB = 4'hF;
    repeat (3) @(posedge REF_CLK);
    RST_N <= 1'b1;
    axi_rd(12'h260, 8'h02);
    axi_rd(12'h02C, 8'h00);
    axi_rd(12'h004, 8'h00);
    `CHK("unmapped resp", RESP_SLVERR, rd_resp)
    i_line.send(8'hA5, 1'b1);
    axi_rd(12'h030, 8'h00);
    axi_wr(12'h060, 8'h90);
    i_line.send(8'hA5, 1'b1);
    axi_rd(12'h030, 8'h20);
    `CHK("masked irq", 1'b0, IRQ)
    `CHK("rx irq off", 1'b0, RECEIVE_IRQ)
    axi_wr(12'h284, 8'h01);
    axi_wr(12'h230, 8'h20);
    axi_wr(12'h02C, 8'h80);
    repeat (2) @(posedge REF_CLK);
    `CHK("irq", 1'b1, IRQ)
    `CHK("rx irq no gate", 1'b0, RECEIVE_IRQ)
    axi_wr(12'h02C, 8'hC0);
    repeat (2) @(posedge REF_CLK);
    `CHK("rx irq", 1'b1, RECEIVE_IRQ)
    `CHK("vector", IRQ_VECTOR_ADDR, IRQ_VECTOR)
    axi_rd(12'h280, 8'h01);
    repeat (2) @(posedge REF_CLK);
    `CHK("irq cleared", 1'b0, IRQ)
    // third word arrives with the fifo full and a bad stop
    i_line.send(8'h3C, 1'b1);
    i_line.send(8'h5A, 1'b0);
    axi_rd(12'h060, 8'h92);
    axi_rd(12'h068, 8'hA5);
    axi_rd(12'h068, 8'h3C);
    axi_rd(12'h030, 8'h00);
    i_line.send(8'h11, 1'b1);
    axi_rd(12'h030, 8'h00);
    axi_wr(12'h060, 8'h80);
    axi_wr(12'h060, 8'h90);
    axi_rd(12'h060, 8'h90);
    i_line.send(8'h96, 1'b0);
    axi_rd(12'h060, 8'h94);
    axi_rd(12'h068, 8'h96);
    axi_rd(12'h060, 8'h90);
    // nine-bit sync slave word received while the core sleeps
    axi_wr(12'h060, 8'h80);
    axi_wr(12'h260, 8'h10);
    axi_rd(12'h260, 8'h12);
    axi_wr(12'h060, 8'hF0);
    SLEEP_ACTIVE <= 1'b1;
    i_line.send_sync(9'h1A5, 9);
    repeat (2) @(posedge REF_CLK);
    `CHK("wake", 1'b1, WAKE_REQ)
    axi_rd(12'h060, 8'hF1);
    axi_rd(12'h068, 8'hA5);
    tally_and_finish;
  end
endmodule
